//--- fpm_ctrl.sv
// Front panel mode controller of a thermocouple panel meter
// What this block does
// - Edit standby idle for auto-return time commits the value, stops blinking.
// - Setting mode idle for auto-return time falls back to measuring.
// - Max/min held 1 s in edit standby discards value, returns to measuring.
// - Decimal setting offers one place or none, default one place.
// - Decimal setting drives point of present/max/min and BCD digit count.
// - Decimal setting leaves compensation, limits, setpoints points unchanged.
// - At power-up all elements light about 3 s, then measuring mode.
// - Out of range blinks range error, sub display shows under or over.
// - Open wire input blinks burnout error; beyond-range input blinks range error only.
// - Measuring with bank switching shows bank number on sub display.
// - Setup/previous alone held 3 s enters initial setting, sensor label.
// - Alarm indicators keep the state latched before leaving measuring.
// - Shift enters blinking edit standby; up steps to next choice.
// - Next or previous in edit standby commits and moves that way.
// - Next steps forward, previous backward through a cyclic list.
// - In initial setting, trim A input follows decimal, unit precedes it.
// - Measuring acquires, evaluates alarms, and follows the power-on lamp test.
// - Measurement stops in every mode other than measuring.
// - Held 3 s from measuring enters alarm, advanced, Modbus or infrared.
// - Next, previous and shift held 5 s enter loop test output.
// - Max/min plus next held preset time enters lockout setting.
// - Next or previous held 1 s in a setting mode returns to measuring.
// - Bargraph limits are skipped when bargraph type is none.
// - Exactly one of Celsius or Fahrenheit indicators is lit.
`timescale 1ns/1ps
`include "fpm_consts.svh"

module fpm_ctrl #(
  parameter int unsigned TICK_CYCLES = `FPM_TICK_NS / `FPM_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] btn_pin,
  input wire logic range_under,
  input wire logic range_over,
  input wire logic wire_open,
  input wire logic [3:0] bank_num,
  input wire logic [3:0] alarm_live,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output fpm_pkg::fpm_mode_e mode,
  output logic [3:0] param_idx,
  output logic edit_blink,
  output logic lamp_all,
  output logic measure_en,
  output logic range_err_ind,
  output logic burnout_ind,
  output fpm_pkg::fpm_label_e sub_label,
  output logic [3:0] sub_bank,
  output logic [3:0] alarm_ind,
  output logic celsius_ind,
  output logic fahrenheit_ind,
  output logic dp_one_place
);
  import fpm_pkg::*;

  logic [4:0] btn_s1;
  logic [4:0] btn;
  logic [4:0] btn_q;
  logic [15:0] tick_cnt;
  logic ms_tick;
  logic [17:0] hold_ms;
  logic [17:0] idle_ms;
  logic [11:0] lamp_ms;
  logic [8:0] blink_ms;
  logic blink_phase;
  logic fired;
  logic editing;
  logic [3:0] cand;
  logic [7:0] autoret_s;
  logic [7:0] lock_s;
  logic bank_en;
  logic [3:0] pmem [0:127];
  fpm_mode_e next_mode;
  logic [3:0] next_pidx;
  logic next_edit;
  logic [3:0] next_cand;
  logic commit;
  logic fire;

  function automatic logic [3:0] last_idx(input fpm_mode_e m);
    case (m)
      FPM_INIT: last_idx = `FPM_INIT_LAST;
      FPM_ALARM, FPM_ADV: last_idx = `FPM_SET_LAST;
      FPM_MODBUS, FPM_LOCK: last_idx = `FPM_SHORT_LAST;
      default: last_idx = 4'h0;
    endcase
  endfunction : last_idx

  function automatic logic [3:0] max_val(input fpm_mode_e m,
                                         input logic [3:0] p);
    max_val = 4'hF;
    if (m == FPM_INIT) begin
      case (p)
        `FPM_P_TYPE: max_val = `FPM_TYPE_MAX;
        `FPM_P_UNIT, `FPM_P_DP: max_val = 4'h1;
        `FPM_P_BAR_TYPE: max_val = `FPM_BAR_MAX;
        default: max_val = 4'hF;
      endcase
    end
  endfunction : max_val

  function automatic logic [3:0] step_idx(input fpm_mode_e m,
                                          input logic [3:0] p,
                                          input logic fwd,
                                          input logic bar_off);
    logic [3:0] n;
    if (fwd) begin
      n = (p >= last_idx(m)) ? 4'h0 : p + 4'h1;
    end else begin
      n = (p == 4'h0) ? last_idx(m) : p - 4'h1;
    end
    if (m == FPM_INIT && bar_off && n >= `FPM_P_BAR_LO) begin
      n = fwd ? 4'h0 : `FPM_P_BAR_TYPE;
    end
    step_idx = n;
  endfunction : step_idx

  // Decoding
  wire [6:0] mem_idx = {mode[2:0], param_idx};
  wire [3:0] cur_val = pmem[mem_idx];
  wire [3:0] unit_val = pmem[{3'(FPM_INIT), `FPM_P_UNIT}];
  wire [3:0] dp_val = pmem[{3'(FPM_INIT), `FPM_P_DP}];
  wire [3:0] bar_val = pmem[{3'(FPM_INIT), `FPM_P_BAR_TYPE}];
  wire edit_bar = editing && mode == FPM_INIT
                  && param_idx == `FPM_P_BAR_TYPE;
  wire bar_off = edit_bar ? (cand == `FPM_BAR_OFF)
                          : (bar_val == `FPM_BAR_OFF);
  wire changed = btn != btn_q;
  // A new button set has been held for no time yet
  wire [17:0] hold_now = changed ? 18'h00000 : hold_ms;
  wire [4:0] press = btn & ~btn_q;
  wire press_next = press[0] && btn == `FPM_B_NEXT;
  wire press_prev = press[1] && btn == `FPM_B_PREV;
  wire press_shift = press[2] && btn == `FPM_B_SHIFT;
  wire press_up = press[3] && btn == `FPM_B_UP;
  wire [17:0] autoret_ms = 18'(autoret_s) * `FPM_MS_PER_S;
  wire [17:0] lock_ms = 18'(lock_s) * `FPM_MS_PER_S;
  wire idle_out = idle_ms >= autoret_ms;
  wire lamp_done = lamp_ms >= `FPM_LAMP_MS;
  wire in_meas = mode == FPM_MEAS;
  wire leave = next_mode != mode || next_edit != editing;

  // Pin synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_s1 <= 5'h00;
      btn <= 5'h00;
      btn_q <= 5'h00;
    end else begin
      btn_s1 <= btn_pin;
      btn <= btn_s1;
      btn_q <= btn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 16'h0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= tick_cnt == 16'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000
                                                      : tick_cnt + 16'h0001;
    end
  end

  // hold counter restarts on any change of the held set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ms <= 18'h00000;
      fired <= 1'b0;
    end else if (changed) begin
      hold_ms <= 18'h00000;
      fired <= 1'b0;
    end else begin
      if (ms_tick && hold_ms != `FPM_HOLD_MAX) begin
        hold_ms <= hold_ms + 18'h00001;
      end
      if (fire) begin
        fired <= 1'b1;
      end
    end
  end

  // idle counter restarts on activity or state change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_ms <= 18'h00000;
    end else if (changed || leave) begin
      idle_ms <= 18'h00000;
    end else if (ms_tick && idle_ms != `FPM_HOLD_MAX) begin
      idle_ms <= idle_ms + 18'h00001;
    end
  end

  // lamp test timer and blink phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_ms <= 12'h000;
      blink_ms <= 9'h000;
      blink_phase <= 1'b0;
    end else if (ms_tick) begin
      if (mode == FPM_LAMP && !lamp_done) begin
        lamp_ms <= lamp_ms + 12'h001;
      end
      blink_ms <= (blink_ms == `FPM_BLINK_MS - 9'h001) ? 9'h000
                                                       : blink_ms + 9'h001;
      if (blink_ms == `FPM_BLINK_MS - 9'h001) begin
        blink_phase <= ~blink_phase;
      end
    end
  end

  // Mode sequencer
  always_comb begin
    next_mode = mode;
    next_pidx = param_idx;
    next_edit = editing;
    next_cand = cand;
    commit = 1'b0;
    fire = 1'b0;
    case (mode)
      FPM_LAMP: begin
        if (lamp_done) begin
          next_mode = FPM_MEAS;
        end
      end
      FPM_MEAS: begin
        if (!fired) begin
          fire = 1'b1;
          if (btn == `FPM_B_PREV && hold_now >= `FPM_ENTER_MS) begin
            next_mode = FPM_INIT;
          end else if (btn == `FPM_B_NEXT && hold_now >= `FPM_ENTER_MS) begin
            next_mode = FPM_ALARM;
          end else if (btn == `FPM_B_ADV && hold_now >= `FPM_ENTER_MS) begin
            next_mode = FPM_ADV;
          end else if (btn == `FPM_B_MODBUS
                       && hold_now >= `FPM_ENTER_MS) begin
            next_mode = FPM_MODBUS;
          end else if (btn == `FPM_B_IR && hold_now >= `FPM_ENTER_MS) begin
            next_mode = FPM_IR;
          end else if (btn == `FPM_B_LOOP && hold_now >= `FPM_LOOP_MS) begin
            next_mode = FPM_LOOP;
          end else if (btn == `FPM_B_LOCK && hold_now >= lock_ms) begin
            next_mode = FPM_LOCK;
          end else begin
            fire = 1'b0;
          end
        end
      end
      FPM_INIT, FPM_ALARM, FPM_ADV, FPM_MODBUS, FPM_IR, FPM_LOCK,
      FPM_LOOP: begin
        if (editing) begin
          if (!fired && btn == `FPM_B_MAXMIN
              && hold_now >= `FPM_ABORT_MS) begin
            next_mode = FPM_MEAS;
            next_edit = 1'b0;
            fire = 1'b1;
          end else if (idle_out) begin
            commit = 1'b1;
            next_edit = 1'b0;
          end else if (press_up) begin
            next_cand = (cand >= max_val(mode, param_idx)) ? 4'h0
                                                           : cand + 4'h1;
          end else if (press_next || press_prev) begin
            commit = 1'b1;
            next_edit = 1'b0;
            next_pidx = step_idx(mode, param_idx, press_next, bar_off);
          end
        end else if (idle_out) begin
          next_mode = FPM_MEAS;
        // long hold of next or previous returns
        end else if (!fired && (btn == `FPM_B_NEXT || btn == `FPM_B_PREV)
                     && hold_now >= `FPM_RETURN_MS) begin
          next_mode = FPM_MEAS;
          fire = 1'b1;
        end else if (press_shift) begin
          next_edit = 1'b1;
          next_cand = cur_val;
        end else if (press_next || press_prev) begin
          next_pidx = step_idx(mode, param_idx, press_next, bar_off);
        end
      end
      default: begin
        next_mode = FPM_MEAS;
      end
    endcase
    if (next_mode != mode) begin
      next_pidx = 4'h0;
      next_edit = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= FPM_LAMP;
      param_idx <= 4'h0;
      editing <= 1'b0;
      cand <= 4'h0;
    end else begin
      mode <= next_mode;
      param_idx <= next_pidx;
      editing <= next_edit;
      cand <= next_cand;
    end
  end

  // every stored value resets to choice 0, which is one place for dp
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 128; i++) begin
        pmem[i] <= 4'h0;
      end
    end else if (commit) begin
      pmem[mem_idx] <= cand;
    end
  end

  // Register port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      autoret_s <= `FPM_AUTORET_RST;
      lock_s <= `FPM_LOCK_RST;
      bank_en <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `FPM_A_AUTORET) begin
        autoret_s <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FPM_A_LOCKHOLD) begin
        lock_s <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FPM_A_CFG) begin
        bank_en <= reg_wdata[0];
      end
      case (reg_addr)
        `FPM_A_AUTORET: reg_rdata <= reg_rd ? autoret_s : 8'h00;
        `FPM_A_LOCKHOLD: reg_rdata <= reg_rd ? lock_s : 8'h00;
        `FPM_A_CFG: reg_rdata <= reg_rd ? {7'h00, bank_en} : 8'h00;
        `FPM_A_STATUS: reg_rdata <= reg_rd ? {editing, 3'h0, mode} : 8'h00;
        `FPM_A_PARAM: reg_rdata <= reg_rd ? {param_idx, cur_val} : 8'h00;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Indicators
  wire fpm_label_e meas_label = range_under ? FPM_L_UNDER
                              : range_over ? FPM_L_OVER
                              : bank_en ? FPM_L_BANK : FPM_L_BLANK;
  wire fpm_label_e set_label =
    (mode == FPM_INIT && param_idx == `FPM_P_TYPE) ? FPM_L_SENSOR
    : (mode == FPM_INIT && param_idx == `FPM_P_TRIM_A_IN) ? FPM_L_TRIM_A
    : FPM_L_PARAM;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edit_blink <= 1'b0;
      lamp_all <= 1'b1;
      measure_en <= 1'b0;
      range_err_ind <= 1'b0;
      burnout_ind <= 1'b0;
      sub_label <= FPM_L_BLANK;
      sub_bank <= 4'h0;
      alarm_ind <= 4'h0;
      celsius_ind <= 1'b1;
      fahrenheit_ind <= 1'b0;
      dp_one_place <= 1'b1;
    end else begin
      edit_blink <= editing && blink_phase;
      lamp_all <= mode == FPM_LAMP;
      measure_en <= in_meas;
      range_err_ind <= in_meas && (range_under || range_over) && blink_phase;
      burnout_ind <= in_meas && wire_open && blink_phase;
      sub_label <= in_meas ? meas_label
                 : (mode == FPM_LAMP) ? FPM_L_BLANK : set_label;
      sub_bank <= bank_num;
      alarm_ind <= in_meas ? alarm_live : alarm_ind;
      celsius_ind <= unit_val == 4'h0;
      fahrenheit_ind <= unit_val != 4'h0;
      // one point output for readings and BCD digits only
      dp_one_place <= dp_val == 4'h0;
    end
  end

  default clocking fpm_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  lamp_exit_a: assert property (
    $past(mode) == FPM_LAMP && mode != FPM_LAMP |->
      mode == FPM_MEAS && $past(lamp_ms) >= `FPM_LAMP_MS)
    else $error("lamp test left early or to the wrong mode");
  idle_return_a: assert property (
    mode != FPM_MEAS && mode != FPM_LAMP && !editing && idle_out
      |=> mode == FPM_MEAS)
    else $error("idle setting mode did not return");
  idle_commit_a: assert property (
    editing && idle_out && !(btn == `FPM_B_MAXMIN && !fired
      && hold_now >= `FPM_ABORT_MS)
      |=> !editing && mode == $past(mode) && $past(cand) == cur_val)
    else $error("idle edit did not commit");
  abort_edit_a: assert property (
    editing && !fired && btn == `FPM_B_MAXMIN && hold_now >= `FPM_ABORT_MS
      |=> mode == FPM_MEAS && !editing)
    else $error("abort did not reach measuring");
  meas_only_a: assert property (
    mode != FPM_MEAS |=> !measure_en)
    else $error("measurement active outside measuring");
  unit_onehot_a: assert property (
    ##1 celsius_ind != fahrenheit_ind)
    else $error("unit indicators not exactly one");
  init_entry_a: assert property (
    $past(mode) == FPM_MEAS && mode == FPM_INIT |->
      $past(btn) == `FPM_B_PREV && $past(hold_now) >= `FPM_ENTER_MS
      && param_idx == `FPM_P_TYPE)
    else $error("initial setting entered without a proper hold");
  exact_set_a: assert property (
    $past(mode) == FPM_MEAS && mode == FPM_ALARM |->
      $past(btn) == `FPM_B_NEXT)
    else $error("alarm setting entered with extra buttons");
  bar_skip_a: assert property (
    mode == FPM_INIT && bar_val == `FPM_BAR_OFF |-> param_idx < `FPM_P_BAR_LO)
    else $error("bargraph limit shown with no bargraph");
  hold_restart_a: assert property (
    changed |=> hold_ms == 18'h00000)
    else $error("hold counter not restarted");
  dp_next_a: assert property (
    mode == FPM_INIT && !editing && param_idx == `FPM_P_DP && press_next
      && !idle_out |=> param_idx == `FPM_P_TRIM_A_IN)
    else $error("wrong parameter after decimal setting");

  enter_init_c: cover property (mode == FPM_MEAS ##1 mode == FPM_INIT);
  abort_c: cover property (editing ##1 mode == FPM_MEAS);
  loop_c: cover property (mode == FPM_MEAS ##1 mode == FPM_LOOP);
  lock_c: cover property (mode == FPM_MEAS ##1 mode == FPM_LOCK);

endmodule : fpm_ctrl

//--- fpm_consts.svh
// Offsets, field codes, reset values and timing counts of the panel controller
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH
// Clock period and timebase tick, both in ns
`define FPM_CLK_NS 25
`define FPM_TICK_NS 1000000
// Times in ms, counted on the 1 ms tick
`define FPM_LAMP_MS 12'hBB8
`define FPM_ENTER_MS 18'h00BB8
`define FPM_LOOP_MS 18'h01388
`define FPM_RETURN_MS 18'h003E8
`define FPM_ABORT_MS 18'h003E8
`define FPM_BLINK_MS 9'h1F4
`define FPM_MS_PER_S 18'h003E8
`define FPM_HOLD_MAX 18'h3FFFF
// Register map and reset values
`define FPM_A_AUTORET 4'h0
`define FPM_A_LOCKHOLD 4'h1
`define FPM_A_CFG 4'h2
`define FPM_A_STATUS 4'h3
`define FPM_A_PARAM 4'h4
`define FPM_AUTORET_RST 8'h0F
`define FPM_LOCK_RST 8'h03
// Button bit sets: 0 alarm/next, 1 setup/prev, 2 shift, 3 up, 4 max/min
`define FPM_B_NEXT 5'h01
`define FPM_B_PREV 5'h02
`define FPM_B_SHIFT 5'h04
`define FPM_B_UP 5'h08
`define FPM_B_MAXMIN 5'h10
`define FPM_B_ADV 5'h03
`define FPM_B_MODBUS 5'h05
`define FPM_B_IR 5'h09
`define FPM_B_LOCK 5'h11
`define FPM_B_LOOP 5'h07
// Initial setting parameter list
`define FPM_P_TYPE 4'h0
`define FPM_P_UNIT 4'h1
`define FPM_P_DP 4'h2
`define FPM_P_TRIM_A_IN 4'h3
`define FPM_P_BAR_TYPE 4'h7
`define FPM_P_BAR_LO 4'h8
`define FPM_INIT_LAST 4'h9
`define FPM_SET_LAST 4'h5
`define FPM_SHORT_LAST 4'h2
`define FPM_TYPE_MAX 4'hD
`define FPM_BAR_MAX 4'h4
`define FPM_BAR_OFF 4'h4
`endif

//--- fpm_pkg.sv
// Types shared by the panel controller
package fpm_pkg;
  typedef enum logic [3:0] {
    FPM_LAMP = 4'h0, FPM_MEAS = 4'h1, FPM_INIT = 4'h2, FPM_ALARM = 4'h3,
    FPM_ADV = 4'h4, FPM_MODBUS = 4'h5, FPM_IR = 4'h6, FPM_LOCK = 4'h7,
    FPM_LOOP = 4'h8
  } fpm_mode_e;
  typedef enum logic [2:0] {
    FPM_L_BLANK = 3'h0, FPM_L_BANK = 3'h1, FPM_L_UNDER = 3'h2,
    FPM_L_OVER = 3'h3, FPM_L_SENSOR = 3'h4, FPM_L_TRIM_A = 3'h5,
    FPM_L_PARAM = 3'h6
  } fpm_label_e;
endpackage : fpm_pkg

//--- fpm_operator.sv
// Operator model: holds a button set for a time, then lets go
`timescale 1ns/1ps
module fpm_operator #(
  parameter int unsigned TICK_CYCLES = 2,
  parameter int unsigned GAP_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] req_set,
  input wire logic [17:0] req_ms,
  input wire logic req_go,
  output logic [4:0] btn_pin,
  output logic busy
);
  logic [31:0] cnt;
  logic released;
  // Released buttons read low; a gap follows each release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_pin <= 5'h00;
      cnt <= 32'h0;
      released <= 1'b0;
      busy <= 1'b0;
    end else if (req_go && !busy) begin
      btn_pin <= req_set;
      cnt <= 32'(req_ms) * TICK_CYCLES;
      released <= 1'b0;
      busy <= 1'b1;
    end else if (busy && cnt != 32'h0) begin
      cnt <= cnt - 32'h1;
    end else if (busy && !released) begin
      btn_pin <= 5'h00;
      cnt <= GAP_CYCLES;
      released <= 1'b1;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule : fpm_operator

//--- fpm_ctrl_bench.sv
// Testbench of the front panel mode controller
`timescale 1ns/1ps
`include "fpm_consts.svh"
module fpm_ctrl_bench;
  import fpm_pkg::*;
  localparam int T = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] op_set = 5'h00;
  logic [17:0] op_ms = 18'h00000;
  logic op_go = 1'b0;
  logic op_busy;
  logic [4:0] btn_pin;
  logic r_under = 1'b0;
  logic r_over = 1'b0;
  logic w_open = 1'b0;
  logic [3:0] alarm_live = 4'h5;
  logic [3:0] bank = 4'h5;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  fpm_mode_e mode;
  fpm_label_e lbl;
  logic [3:0] pidx, sbank, alarm_ind;
  logic blink, lamp, meas, rerr, berr, c_ind, f_ind, dp1;
  logic seen_hi, seen_lo, seen_b;
  int n_errors = 0;
  int samples_checked = 0;
  int i;
  logic [4:0] sets [5] = '{`FPM_B_ADV, `FPM_B_MODBUS, `FPM_B_IR,
    `FPM_B_LOOP, `FPM_B_LOCK};
  fpm_mode_e modes [5] = '{FPM_ADV, FPM_MODBUS, FPM_IR, FPM_LOOP, FPM_LOCK};
  int hold_ms [5] = '{3050, 3050, 3050, 5050, 1050};

  always #12.5 clk = ~clk;

  fpm_ctrl #(.TICK_CYCLES(T)) u_fpm_ctrl (.clk(clk), .rst_n(rst_n),
    .btn_pin(btn_pin), .range_under(r_under), .range_over(r_over),
    .wire_open(w_open), .bank_num(bank), .alarm_live(alarm_live),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .mode(mode), .param_idx(pidx), .edit_blink(blink),
    .lamp_all(lamp), .measure_en(meas), .range_err_ind(rerr),
    .burnout_ind(berr), .sub_label(lbl), .sub_bank(sbank),
    .alarm_ind(alarm_ind), .celsius_ind(c_ind), .fahrenheit_ind(f_ind),
    .dp_one_place(dp1));

  fpm_operator #(.TICK_CYCLES(T)) u_fpm_operator (.clk(clk), .rst_n(rst_n),
    .req_set(op_set), .req_ms(op_ms), .req_go(op_go), .btn_pin(btn_pin),
    .busy(op_busy));

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("reg_rdata", rdata, exp);
  endtask : reg_chk

  task automatic press(input logic [4:0] set, input int ms);
    int k;
    @(posedge clk);
    op_set <= set;
    op_ms <= 18'(ms);
    op_go <= 1'b1;
    @(posedge clk);
    op_go <= 1'b0;
    for (k = 0; k < ms * T + 100; k++) begin
      @(posedge clk);
      #1;
      if (!op_busy) break;
    end
    if (op_busy) begin
      n_errors++;
      $display("[ERR] operator hold did not finish");
      test_done();
    end
  endtask : press

  task automatic wait_mode(input fpm_mode_e m, input int ms);
    int k;
    for (k = 0; k < ms * T && mode !== m; k++) begin
      @(posedge clk);
      #1;
    end
    check("mode", 8'(mode), 8'(m));
    if (mode !== m) test_done();
  endtask : wait_mode

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("lamp_all", 8'(lamp), 8'h01);
    check("celsius", 8'(c_ind), 8'h01);
    check("dp_one_place", 8'(dp1), 8'h01);
    reg_chk(`FPM_A_AUTORET, `FPM_AUTORET_RST);
    reg_chk(`FPM_A_LOCKHOLD, `FPM_LOCK_RST);
    reg_wr(`FPM_A_AUTORET, 8'h01);
    reg_wr(`FPM_A_LOCKHOLD, 8'h01);
    reg_wr(`FPM_A_CFG, 8'h01);
    reg_wr(`FPM_A_STATUS, 8'hFF);
    reg_wr(4'h5, 8'hFF);
    reg_chk(`FPM_A_AUTORET, 8'h01);
    reg_chk(`FPM_A_CFG, 8'h01);
    reg_chk(`FPM_A_STATUS, 8'h00);
    reg_chk(4'h5, 8'h00);
    wait_mode(FPM_MEAS, 3100);
    repeat (3) @(posedge clk);
    #1;
    check("lamp_all", 8'(lamp), 8'h00);
    check("measure_en", 8'(meas), 8'h01);
    check("alarm_ind", 8'(alarm_ind), 8'h05);
    check("sub_label", 8'(lbl), 8'(FPM_L_BANK));
    check("sub_bank", 8'(sbank), 8'h05);
    r_under <= 1'b1;
    bank <= 4'h3;
    repeat (4) @(posedge clk);
    #1;
    check("sub_label", 8'(lbl), 8'(FPM_L_UNDER));
    check("sub_bank", 8'(sbank), 8'h03);
    r_under <= 1'b0;
    r_over <= 1'b1;
    w_open <= 1'b1;
    seen_hi = 1'b0;
    seen_lo = 1'b0;
    seen_b = 1'b0;
    for (i = 0; i < 1200 * T; i++) begin
      @(posedge clk);
      #1;
      seen_hi |= rerr;
      seen_lo |= !rerr;
      seen_b |= berr;
    end
    check("sub_label", 8'(lbl), 8'(FPM_L_OVER));
    check("range_err blink", {6'h0, seen_hi, seen_lo}, 8'h03);
    check("burnout_ind", 8'(seen_b), 8'h01);
    r_over <= 1'b0;
    w_open <= 1'b0;
    press(`FPM_B_PREV, 3050);
    check("mode", 8'(mode), 8'(FPM_INIT));
    check("param_idx", 8'(pidx), 8'h00);
    check("sub_label", 8'(lbl), 8'(FPM_L_SENSOR));
    check("measure_en", 8'(meas), 8'h00);
    alarm_live <= 4'hA;
    repeat (4) @(posedge clk);
    #1;
    check("alarm_ind", 8'(alarm_ind), 8'h05);
    press(`FPM_B_PREV, 3);
    check("param_idx", 8'(pidx), 8'h09);
    press(`FPM_B_NEXT, 3);
    press(`FPM_B_NEXT, 3);
    press(`FPM_B_SHIFT, 3);
    reg_chk(`FPM_A_STATUS, 8'h82);
    press(`FPM_B_UP, 3);
    press(`FPM_B_NEXT, 3);
    check("param_idx", 8'(pidx), 8'h02);
    reg_chk(`FPM_A_PARAM, 8'h20);
    check("unit ind", {6'h0, c_ind, f_ind}, 8'h01);
    press(`FPM_B_PREV, 3);
    check("param_idx", 8'(pidx), 8'h01);
    press(`FPM_B_NEXT, 3);
    press(`FPM_B_NEXT, 3);
    check("sub_label", 8'(lbl), 8'(FPM_L_TRIM_A));
    press(`FPM_B_PREV, 3);
    press(`FPM_B_SHIFT, 3);
    press(`FPM_B_UP, 3);
    seen_hi = 1'b0;
    for (i = 0; i < 1050 * T; i++) begin
      @(posedge clk);
      #1;
      seen_hi |= blink;
    end
    check("edit_blink", 8'(seen_hi), 8'h01);
    check("edit_blink", 8'(blink), 8'h00);
    reg_chk(`FPM_A_STATUS, 8'h02);
    check("dp_one_place", 8'(dp1), 8'h00);
    for (i = 0; i < 5; i++) begin
      press(`FPM_B_NEXT, 3);
    end
    press(`FPM_B_SHIFT, 3);
    for (i = 0; i < 4; i++) begin
      press(`FPM_B_UP, 3);
    end
    press(`FPM_B_NEXT, 3);
    check("param_idx", 8'(pidx), 8'h00);
    press(`FPM_B_PREV, 3);
    check("param_idx", 8'(pidx), 8'h07);
    wait_mode(FPM_MEAS, 1100);
    press(`FPM_B_NEXT, 3050);
    check("mode", 8'(mode), 8'(FPM_ALARM));
    press(`FPM_B_SHIFT, 3);
    press(`FPM_B_UP, 3);
    press(`FPM_B_MAXMIN, 1050);
    check("mode", 8'(mode), 8'(FPM_MEAS));
    reg_wr(`FPM_A_AUTORET, 8'h02);
    for (i = 0; i < 5; i++) begin
      press(sets[i], hold_ms[i]);
      check("mode", 8'(mode), 8'(modes[i]));
      press(`FPM_B_NEXT, 1050);
      check("mode", 8'(mode), 8'(FPM_MEAS));
    end
    test_done();
  end
endmodule : fpm_ctrl_bench
